// ==== src/cbfc_top.sv ====
//  Function
// - input mask sets words per input block
// - input start gives first unit write offset
// - output mask sets words per output block
// - output start gives first unit read offset
// - input transfer stops at count zero
// - mode pin selects bus personality
// - bursts only in second mode, buffers only
// - bursts are always eight words
// - one input, one output 4096-bit buffer
// - buffer reached through one address
// - each request line maps to either buffer
// - after reset a=input, b=output
// - input request when eight words free, second mode only
// - output request while eight words unread, second mode only
`timescale 1ns/100ps
`default_nettype none
module cbfc_top
   import cbfc_pkg::*;
#(
   parameter int DEPTH = BUF_WORDS
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [31:0] regRdata,
   // static personality pin and burst flag
   input  wire logic        busModePin,
   input  wire logic        burstReq,
   // dma request lines, active low
   output logic             dmaRequestAN,
   output logic             dmaRequestBN,
   // execution unit side
   output cbfc_eu_req_t     euReq,
   input  wire logic [31:0] euRdata
);
   localparam int LW = $clog2(DEPTH) + 1;

   typedef struct packed {
      cbfc_ctl_t   inCtl;
      cbfc_ctl_t   outCtl;
      logic [31:0] inCnt;
      logic [31:0] outCnt;
      logic        mapA;
      logic        mapB;
      logic [7:0]  inIdx;
      logic [7:0]  outIdx;
      logic        outPend;
      logic [31:0] rdata;
      logic [3:0]  burstLeft;
      cbfc_eu_req_t eu;
   } cbfc_st_t;

   cbfc_st_t st;
   cbfc_st_t next_st;

   // personality pin synchroniser
   logic modeMeta;
   logic modeSync;

   // fifo wires
   logic        ibInValid;
   logic        ibInReady;
   logic        ibOutValid;
   logic        ibOutReady;
   logic [31:0] ibOutData;
   logic [LW-1:0] ibLevel;
   logic        obInValid;
   logic        obInReady;
   logic        obOutValid;
   logic        obOutReady;
   logic [31:0] obOutData;
   logic [LW-1:0] obLevel;
   logic        inReq;
   logic        outReq;
   logic        bufWr;
   logic        bufRd;

   // next offset within a block, wraps at the mask count
   function automatic logic [7:0] step_idx(input logic [7:0] idx, input logic [7:0] mask);
      step_idx = (idx + 8'h01 >= mask) ? 8'h00 : idx + 8'h01;
   endfunction

   // two-flop capture of the static pin
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         modeMeta <= 1'b0;
         modeSync <= 1'b0;
      end
      else
      begin
         modeMeta <= busModePin;
         modeSync <= modeMeta;
      end
   end

   // buffer port accesses; bursts start only in second mode
   assign bufWr = regWrite && (regAddr == OFS_INPUT_BUFFER_PORT);
   assign bufRd = regRead && (regAddr == OFS_OUTPUT_BUFFER_PORT);
   assign ibInValid  = bufWr;
   assign obOutReady = bufRd;

   // input buffer drains into the unit until count is zero
   assign ibOutReady = (st.inCnt != '0) && !st.outPend;
   // output side pulls one word in the same cycle as its read pulse
   assign obInValid  = st.outPend;

   // dma request levels
   assign inReq  = modeSync && ((LW)'(DEPTH) - ibLevel >= (LW)'(BURST_WORDS));
   assign outReq = modeSync && (obLevel >= (LW)'(BURST_WORDS));

   // main next-state logic
   always_comb
   begin
      next_st = st;
      next_st.eu.write = 1'b0;
      next_st.eu.read  = 1'b0;
      next_st.rdata    = '0;
      next_st.outPend  = 1'b0;
      // burst tracking: a burst start claims eight beats
      if ((bufWr || bufRd) && modeSync && burstReq && st.burstLeft == '0)
      begin
         next_st.burstLeft = 4'(BURST_WORDS - 1);
      end
      else if ((bufWr || bufRd) && st.burstLeft != '0)
         next_st.burstLeft = st.burstLeft - 4'h1;
      // input word into unit at start plus block offset
      if (ibOutValid && ibOutReady)
      begin
         next_st.eu.write = 1'b1;
         next_st.eu.addr  = st.inCtl.start + 12'(st.inIdx);
         next_st.eu.wdata = ibOutData;
         next_st.inIdx    = step_idx(st.inIdx, st.inCtl.mask);
         next_st.inCnt    = st.inCnt - 32'h1;
      end
      // output word from unit at start plus block offset
      else if (st.outCnt != '0 && obInReady && !st.outPend)
      begin
         next_st.eu.read = 1'b1;
         next_st.eu.addr = st.outCtl.start + 12'(st.outIdx);
         next_st.outIdx  = step_idx(st.outIdx, st.outCtl.mask);
         next_st.outCnt  = st.outCnt - 32'h1;
         next_st.outPend = 1'b1;
      end
      // register writes, after the mover so a software write wins
      if (regWrite)
      begin
         unique case (regAddr)
            OFS_INPUT_BUFFER_CONTROL:
            begin
               next_st.inCtl = regWdata;
               next_st.inIdx = '0;
            end
            OFS_OUTPUT_BUFFER_CONTROL:
            begin
               next_st.outCtl = regWdata;
               next_st.outIdx = '0;
            end
            OFS_INPUT_WORD_COUNT:  next_st.inCnt  = regWdata;
            OFS_OUTPUT_WORD_COUNT: next_st.outCnt = regWdata;
            OFS_CONTROLLER_STATUS:
            begin
               next_st.mapA = regWdata[MAP_A_BIT];
               next_st.mapB = regWdata[MAP_B_BIT];
            end
            default: ;
         endcase
      end
      // register reads, data in the next cycle
      if (regRead)
      begin
         unique case (regAddr)
            OFS_INPUT_BUFFER_CONTROL:  next_st.rdata = st.inCtl;
            OFS_OUTPUT_BUFFER_CONTROL: next_st.rdata = st.outCtl;
            OFS_INPUT_WORD_COUNT:      next_st.rdata = st.inCnt;
            OFS_OUTPUT_WORD_COUNT:     next_st.rdata = st.outCnt;
            OFS_CONTROLLER_STATUS:
            begin
               next_st.rdata[MAP_A_BIT]    = st.mapA;
               next_st.rdata[MAP_B_BIT]    = st.mapB;
               next_st.rdata[IN_BUSY_BIT]  = (st.inCnt != '0);
               next_st.rdata[OUT_BUSY_BIT] = (st.outCnt != '0);
               next_st.rdata[MODE_BIT]     = modeSync;
            end
            OFS_OUTPUT_BUFFER_PORT: next_st.rdata = obOutValid ? obOutData : '0;
            default: next_st.rdata = '0;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st        <= '0;
         st.inCtl  <= RST_CONTROL;
         st.outCtl <= RST_CONTROL;
         st.inCnt  <= RST_COUNT;
         st.outCnt <= RST_COUNT;
         st.mapA   <= RST_MAP_A;
         st.mapB   <= RST_MAP_B;
      end
      else
         st <= next_st;
   end

   // input and output buffers of 4096 bits each
   cbfc_fifo #(.WIDTH(WORD_BITS), .DEPTH(DEPTH)) inBuf
   (
      .clk      (clk),
      .resetn   (resetn),
      .inValid  (ibInValid),
      .inReady  (ibInReady),
      .inData   (regWdata),
      .outValid (ibOutValid),
      .outReady (ibOutReady),
      .outData  (ibOutData),
      .level    (ibLevel)
   );

   cbfc_fifo #(.WIDTH(WORD_BITS), .DEPTH(DEPTH)) outBuf
   (
      .clk      (clk),
      .resetn   (resetn),
      .inValid  (obInValid),
      .inReady  (obInReady),
      .inData   (euRdata),
      .outValid (obOutValid),
      .outReady (obOutReady),
      .outData  (obOutData),
      .level    (obLevel)
   );

   // outputs; request lines are active low and mapped
   assign dmaRequestAN = !(st.mapA ? outReq : inReq);
   assign dmaRequestBN = !(st.mapB ? outReq : inReq);
   assign regRdata     = st.rdata;
   assign euReq        = st.eu;

   // unit-side transfer checks
   a_in_stop: assert property (@(posedge clk) disable iff (!resetn)
      (st.inCnt == '0 && !(regWrite && regAddr == OFS_INPUT_WORD_COUNT))
      |=> !st.eu.write) else $error("input moved with zero count");
   a_in_dec: assert property (@(posedge clk) disable iff (!resetn)
      (ibOutValid && ibOutReady && !regWrite) |=> st.inCnt == $past(st.inCnt) - 1)
      else $error("input count not decremented");
   a_in_addr: assert property (@(posedge clk) disable iff (!resetn)
      st.eu.write |-> st.eu.addr == $past(st.inCtl.start) + 12'($past(st.inIdx)))
      else $error("input address wrong");
   a_in_wrap: assert property (@(posedge clk) disable iff (!resetn)
      (!regWrite && st.inCtl.mask != '0) |=> st.inIdx < $past(st.inCtl.mask))
      else $error("input offset beyond mask");
   a_eu_data: assert property (@(posedge clk) disable iff (!resetn)
      st.eu.write |-> st.eu.wdata == $past(ibOutData))
      else $error("unit write data not the oldest buffer word");
   a_in_priority: assert property (@(posedge clk) disable iff (!resetn)
      (ibOutValid && ibOutReady) |=> !st.eu.read)
      else $error("output read beside an input move");
   a_out_addr: assert property (@(posedge clk) disable iff (!resetn)
      st.eu.read |-> st.eu.addr == $past(st.outCtl.start) + 12'($past(st.outIdx)))
      else $error("output address wrong");
   a_out_wrap: assert property (@(posedge clk) disable iff (!resetn)
      (!regWrite && st.outCtl.mask != '0) |=> st.outIdx < $past(st.outCtl.mask))
      else $error("output offset beyond mask");
   a_out_stop: assert property (@(posedge clk) disable iff (!resetn)
      (st.outCnt == '0 && !(regWrite && regAddr == OFS_OUTPUT_WORD_COUNT))
      |=> !st.eu.read) else $error("output moved with zero count");
   a_out_dec: assert property (@(posedge clk) disable iff (!resetn)
      (st.eu.read && !$past(regWrite)) |-> st.outCnt == $past(st.outCnt) - 1)
      else $error("output count not decremented");
   a_one_request: assert property (@(posedge clk) disable iff (!resetn)
      st.eu.write |-> !st.eu.read)
      else $error("read and write to the unit together");

   // output fetch: read pulse and capture share a cycle, then a gap
   sequence s_out_fetch;
      st.eu.read && st.outPend;
   endsequence
   sequence s_out_quiet;
      !st.eu.read && !st.outPend;
   endsequence
   a_out_capture: assert property (@(posedge clk) disable iff (!resetn)
      st.eu.read |-> s_out_fetch ##1 s_out_quiet)
      else $error("output read not captured once");

   // register writes win over the mover in the same cycle; read data zero outside the answer cycle
   a_in_load: assert property (@(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == OFS_INPUT_WORD_COUNT) |=> st.inCnt == $past(regWdata))
      else $error("input count write lost");
   a_out_load: assert property (@(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == OFS_OUTPUT_WORD_COUNT) |=> st.outCnt == $past(regWdata))
      else $error("output count write lost");
   a_in_restart: assert property (@(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == OFS_INPUT_BUFFER_CONTROL) |=> st.inIdx == '0)
      else $error("input offset not restarted");
   a_out_restart: assert property (@(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == OFS_OUTPUT_BUFFER_CONTROL) |=> st.outIdx == '0)
      else $error("output offset not restarted");
   a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
      !$past(regRead) |-> regRdata == '0)
      else $error("read data outside the answer cycle");

   // buffer and request line checks
   a_full_refuse: assert property (@(posedge clk) disable iff (!resetn)
      (bufWr && !ibInReady && !ibOutReady) |=> $stable(ibLevel))
      else $error("write into a full input buffer");
   a_req_in: assert property (@(posedge clk) disable iff (!resetn)
      (!st.mapA) |-> (dmaRequestAN == !(modeSync && (DEPTH - ibLevel) >= BURST_WORDS)))
      else $error("input request level wrong");
   a_req_out: assert property (@(posedge clk) disable iff (!resetn)
      st.mapB |-> (dmaRequestBN == !(modeSync && obLevel >= BURST_WORDS)))
      else $error("output request level wrong");
   a_req_a_out: assert property (@(posedge clk) disable iff (!resetn)
      st.mapA |-> (dmaRequestAN == !(modeSync && obLevel >= BURST_WORDS)))
      else $error("line a output mapping wrong");
   a_req_b_in: assert property (@(posedge clk) disable iff (!resetn)
      (!st.mapB) |-> (dmaRequestBN == !(modeSync && (DEPTH - ibLevel) >= BURST_WORDS)))
      else $error("line b input mapping wrong");
   a_first_mode: assert property (@(posedge clk) disable iff (!resetn)
      !modeSync |-> (dmaRequestAN && dmaRequestBN))
      else $error("request line active in first mode");
   a_burst_len: assert property (@(posedge clk) disable iff (!resetn)
      $rose(st.burstLeft != '0) |-> st.burstLeft == 4'(BURST_WORDS - 1))
      else $error("burst not eight beats");
   a_mode_burst: assert property (@(posedge clk) disable iff (!resetn)
      (!modeSync && st.burstLeft == '0) |=> st.burstLeft == '0)
      else $error("burst in first mode");
endmodule
`default_nettype wire

// ==== src/cbfc_pkg.sv ====
package cbfc_pkg;

   // register offsets (byte addresses, one word each)
   localparam logic [7:0] OFS_INPUT_BUFFER_CONTROL  = 8'h00;
   localparam logic [7:0] OFS_OUTPUT_BUFFER_CONTROL = 8'h04;
   localparam logic [7:0] OFS_INPUT_WORD_COUNT      = 8'h08;
   localparam logic [7:0] OFS_OUTPUT_WORD_COUNT     = 8'h0c;
   localparam logic [7:0] OFS_CONTROLLER_STATUS     = 8'h10;
   localparam logic [7:0] OFS_INPUT_BUFFER_PORT     = 8'h20;
   localparam logic [7:0] OFS_OUTPUT_BUFFER_PORT    = 8'h24;

   // field positions of the buffer control registers
   localparam int MASK_LSB  = 8;
   localparam int MASK_MSB  = 15;
   localparam int START_LSB = 20;
   localparam int START_MSB = 31;

   // controller status/control fields
   localparam int MAP_A_BIT   = 0;
   localparam int MAP_B_BIT   = 1;
   localparam int IN_BUSY_BIT = 8;
   localparam int OUT_BUSY_BIT = 9;
   localparam int MODE_BIT    = 10;

   // reset values
   localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
   localparam logic [31:0] RST_COUNT   = 32'h0000_0000;
   localparam logic        RST_MAP_A   = 1'b0;  // 0 = input buffer
   localparam logic        RST_MAP_B   = 1'b1;  // 1 = output buffer

   // buffer geometry and burst
   localparam int BUF_BITS    = 4096;
   localparam int WORD_BITS   = 32;
   localparam int BUF_WORDS   = BUF_BITS / WORD_BITS;
   localparam int BURST_WORDS = 8;

   // execution unit side request
   typedef struct packed {
      logic        write;
      logic        read;
      logic [11:0] addr;
      logic [31:0] wdata;
   } cbfc_eu_req_t;

   // buffer control register layout
   typedef struct packed {
      logic [11:0] start;
      logic [3:0]  rsv1;
      logic [7:0]  mask;
      logic [7:0]  rsv0;
   } cbfc_ctl_t;

endpackage

// ==== src/cbfc_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module cbfc_fifo
   import cbfc_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData,
   // fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } cbfc_fifo_st_t;

   cbfc_fifo_st_t st;
   cbfc_fifo_st_t next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // handshake and pointer update
   always_comb
   begin
      inReady  = (st.cnt != (AW+1)'(DEPTH));
      outValid = (st.cnt != '0);
      push     = inValid && inReady;
      pop      = outValid && outReady;
      next_st  = st;
      if (push)
         next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
      if (pop)
         next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // state register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         st <= '0;
      else
         st <= next_st;
   end

   // storage array
   always_ff @(posedge clk)
   begin
      if (push)
         mem[st.wp] <= inData;
   end

   assign outData = mem[st.rp];
   assign level   = st.cnt;

   a_fifo_count: assert property (@(posedge clk) disable iff (!resetn)
      (push && !pop) |=> (st.cnt == $past(st.cnt) + 1'b1))
      else $error("fifo level did not rise on push");
endmodule
`default_nettype wire

// ==== verification/cbfc_eu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cbfc_eu_model
   import cbfc_pkg::*;
(
   // clock
   input  wire logic         clk,
   // unit side of the block
   input  wire cbfc_eu_req_t euReq,
   output logic      [31:0]  euRdata
);
   logic [31:0] mem [4096];

   // seeded contents, so every read word is known by its address
   initial
   begin
      for (int i = 0; i < 4096; i++)
         mem[i] = {8'ha5, 12'(i), 12'(~i)};
   end

   // stores writes at the edge that ends the write pulse
   always @(posedge clk)
   begin
      if (euReq.write)
         mem[euReq.addr] <= euReq.wdata;
   end

   // read data stand while the read pulse does; the block captures at its end
   always_comb
   begin
      if (euReq.read)
         euRdata = mem[euReq.addr];
      else
         euRdata = ~mem[euReq.addr];  // inverse outside an answer, no stale word
   end
endmodule
`default_nettype wire

// ==== verification/cbfc_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module cbfc_bench
   import cbfc_pkg::*;
   ;
   localparam int          DEPTH_T   = 16;
   localparam logic [11:0] IN_START  = 12'hffe;
   localparam logic [11:0] OUT_START = 12'h100;

   logic         clk;
   logic         resetn;
   logic [7:0]   regAddr;
   logic [31:0]  regWdata;
   logic         regWrite;
   logic         regRead;
   logic [31:0]  regRdata;
   logic         busModePin;
   logic         burstReq;
   logic         dmaRequestAN;
   logic         dmaRequestBN;
   cbfc_eu_req_t euReq;
   logic [31:0]  euRdata;
   logic         rdPrev = 1'b0;
   int           errors = 0;
   int           n_compared = 0;
   logic [43:0]  euQ [$];
   logic [31:0]  rdQ [$];
   logic [31:0]  word [DEPTH_T+2];

   cbfc_top #(.DEPTH(DEPTH_T)) u_dut (
      .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .busModePin(busModePin), .burstReq(burstReq), .dmaRequestAN(dmaRequestAN),
      .dmaRequestBN(dmaRequestBN), .euReq(euReq), .euRdata(euRdata));

   cbfc_eu_model u_eu (.clk(clk), .euReq(euReq), .euRdata(euRdata));

   // free-running clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] euWord(input logic [11:0] a);
      return {8'ha5, a, ~a};
   endfunction

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("errors %0d, compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
      regWrite <= w;
      regRead  <= r;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      rdQ.push_back(exp);
      bus(1'b0, 1'b1, a, 32'h0);
   endtask

   task automatic idle(input int n);
      regWrite <= 1'b0;
      regRead  <= 1'b0;
      burstReq <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   task automatic dmaChk(input logic a, input logic b);
      #1;
      check("dmaRequestAN", 64'(dmaRequestAN), 64'(a));
      check("dmaRequestBN", 64'(dmaRequestBN), 64'(b));
      @(posedge clk);
   endtask

   // compares unit writes and read data with the oldest notes
   always @(posedge clk)
   begin
      if (euReq.write)
      begin
         if (euQ.size() == 0)
            check("unit write beyond count", 64'(1), 64'(0));
         else
            check("unit write", 64'({euReq.addr, euReq.wdata}), 64'(euQ.pop_front()));
      end
      if (rdPrev)
         check("regRdata", 64'(regRdata), 64'(rdQ.pop_front()));
      rdPrev = regRead;
   end

   // hang guard
   initial
   begin
      repeat (2000) @(posedge clk);
      errors++;
      finish_test;
   end

   // main sequence
   initial
   begin
      logic [31:0] v;
      logic [7:0]  a;
      resetn = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      busModePin = 1'b0;
      burstReq = 1'b0;
      void'($urandom(32'hffad));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      dmaChk(1'b1, 1'b1);
      rd(OFS_CONTROLLER_STATUS, 32'h0000_0002);
      rd(OFS_INPUT_BUFFER_CONTROL, RST_CONTROL);
      rd(OFS_INPUT_WORD_COUNT, RST_COUNT);
      rd(8'h3c, 32'h0);
      // random control values with reserved bits clear
      for (int k = 0; k < 4; k++)
      begin
         v = $urandom() & 32'hfff0_ff00;
         a = k[0] ? OFS_OUTPUT_BUFFER_CONTROL : OFS_INPUT_BUFFER_CONTROL;
         bus(1'b1, 1'b0, a, v);
         rd(a, v);
      end
      busModePin <= 1'b1;
      bus(1'b1, 1'b0, OFS_INPUT_BUFFER_CONTROL, {IN_START, 4'h0, 8'h04, 8'h00});
      bus(1'b1, 1'b0, OFS_OUTPUT_BUFFER_CONTROL, {OUT_START, 4'h0, 8'h02, 8'h00});
      idle(4);
      dmaChk(1'b0, 1'b1);
      // two eight-word bursts, then two words the full buffer drops
      for (int k = 0; k < DEPTH_T + 2; k++)
      begin
         word[k] = $urandom();
         burstReq <= (k % 8 == 0) && (k < DEPTH_T);
         bus(1'b1, 1'b0, OFS_INPUT_BUFFER_PORT, word[k]);
      end
      idle(2);
      dmaChk(1'b1, 1'b1);
      for (int k = 0; k < 14; k++)
         euQ.push_back({IN_START + 12'(k % 4), word[k]});
      bus(1'b1, 1'b0, OFS_INPUT_WORD_COUNT, 32'd14);
      rd(OFS_CONTROLLER_STATUS, 32'h0000_0502);
      idle(40);
      rd(OFS_INPUT_WORD_COUNT, 32'h0);
      idle(2);
      dmaChk(1'b0, 1'b1);
      bus(1'b1, 1'b0, OFS_OUTPUT_WORD_COUNT, 32'd10);
      rd(OFS_CONTROLLER_STATUS, 32'h0000_0602);
      idle(40);
      dmaChk(1'b0, 1'b0);
      for (int k = 0; k < 10; k++)
      begin
         rd(OFS_OUTPUT_BUFFER_PORT, euWord(OUT_START + 12'(k % 2)));
         if (k == 2)
         begin
            idle(2);
            dmaChk(1'b0, 1'b1);
         end
      end
      rd(OFS_OUTPUT_BUFFER_PORT, 32'h0);
      rd(OFS_OUTPUT_WORD_COUNT, 32'h0);
      bus(1'b1, 1'b0, OFS_CONTROLLER_STATUS, 32'h0000_0001);
      idle(2);
      dmaChk(1'b1, 1'b0);
      busModePin <= 1'b0;
      idle(4);
      dmaChk(1'b1, 1'b1);
      finish_test;
   end
endmodule
`default_nettype wire
